/* hdl/rvm_pkg.sv */
package rvm_pkg;
  // Regulator counts: seven bucks then four linear regulators.
  localparam int unsigned NUM_BUCK = 7;
  localparam int unsigned NUM_LIN = 4;
  localparam int unsigned NUM_REG = 11;
  localparam int unsigned CLK_MHZ = 50;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_MON_EN = 6'h04;
  localparam logic [5:0] OFS_SECURE_KEY = 6'h08;
  localparam logic [5:0] OFS_LOW_SEL = 6'h0C;
  localparam logic [5:0] OFS_HIGH_SEL = 6'h10;
  localparam logic [5:0] OFS_LOW_STAT = 6'h14;
  localparam logic [5:0] OFS_HIGH_STAT = 6'h18;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFS_REF_STAT = 6'h24;

  // Control register field positions.
  localparam int unsigned CTRL_LOW_DB_LSB = 0;
  localparam int unsigned CTRL_HIGH_DB_LSB = 2;
  localparam int unsigned CTRL_SECURE_BIT = 4;
  localparam int unsigned CTRL_IRQ_ONLY_BIT = 5;

  // Interrupt status bit positions.
  localparam int unsigned IRQ_LOW_BIT = 0;
  localparam int unsigned IRQ_HIGH_BIT = 1;
  localparam int unsigned IRQ_REF_BIT = 2;

  // Reset values.
  localparam logic [1:0] LOW_DB_RST = 2'h2;
  localparam logic [1:0] HIGH_DB_RST = 2'h0;
  localparam logic [10:0] MON_EN_RST = 11'h7FF;
  localparam logic [31:0] SECURE_KEY = 32'h5EC0_0A11;

  // Trip percentages as encoded by the two-bit selects.
  localparam logic [6:0] LOW_PCT_0 = 7'd95;
  localparam logic [6:0] LOW_PCT_1 = 7'd93;
  localparam logic [6:0] LOW_PCT_2 = 7'd91;
  localparam logic [6:0] LOW_PCT_3 = 7'd89;
  localparam logic [6:0] HIGH_PCT_0 = 7'd105;
  localparam logic [6:0] HIGH_PCT_1 = 7'd107;
  localparam logic [6:0] HIGH_PCT_2 = 7'd109;
  localparam logic [6:0] HIGH_PCT_3 = 7'd111;

  // Debounce times in microseconds and the cycle counter width.
  localparam int unsigned LOW_DB_US_0 = 5;
  localparam int unsigned LOW_DB_US_1 = 15;
  localparam int unsigned LOW_DB_US_2 = 25;
  localparam int unsigned LOW_DB_US_3 = 40;
  localparam int unsigned HIGH_DB_US_0 = 25;
  localparam int unsigned HIGH_DB_US_1 = 50;
  localparam int unsigned HIGH_DB_US_2 = 80;
  localparam int unsigned HIGH_DB_US_3 = 125;
  localparam int unsigned CNT_W = 13;

  typedef enum logic [1:0] {
    RVM_OFF = 2'b00,
    RVM_MASKED = 2'b01,
    RVM_WATCH = 2'b11
  } rvm_state_e;
endpackage

/* hdl/rvm_regulator_voltage_monitor.sv */
// Contract
// - One monitor per buck and linear regulator.
// - Low select maps to 95/93/91/89 percent.
// - High select maps to 105/107/109/111 percent.
// - Shared low debounce 5/15/25/40 us.
// - Low debounce resets to 0b10.
// - Shared high debounce 25/50/80/125 us.
// - High debounce resets to 0b00.
// - Per-regulator enable gates its monitoring.
// - All monitor enables reset to one.
// - Secure mode ignores ordinary enable writes.
// - Faults masked until regulation reached.
// - Disabling monitor clears its status.
// - Reference drift blocks switching power-up.
// - Drift, bypass zero: shut power stages.
// - Drift, bypass one: interrupt only.
// - Reference failure sets maskable interrupt flag.
// - Reference status follows live condition.
`timescale 1ns/100ps
`default_nettype none
module rvm_regulator_voltage_monitor
  import rvm_pkg::*;
#(
  parameter int unsigned N_REG = NUM_REG,
  parameter int unsigned MHZ = CLK_MHZ
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Analog comparator and regulator state pins.
  input wire logic [10:0] low_cmp_i,
  input wire logic [10:0] high_cmp_i,
  input wire logic [10:0] reg_on_i,
  input wire logic [10:0] in_regulation_i,
  input wire logic ref_drift_i,
  input wire logic system_on_i,
  // Trip level codes for the comparator DACs.
  output logic [76:0] low_trip_pct_o,
  output logic [76:0] high_trip_pct_o,
  // Power control and interrupt.
  output logic switching_powerup_block_o,
  output logic power_stage_shutdown_o,
  output logic irq_o
);

  // Elaboration check: the bank size is fixed by the register layout, and the counters
  // must hold the longest debounce while the shortest still spans more than one cycle.
  if (N_REG != NUM_REG || MHZ == 0 || HIGH_DB_US_3 * MHZ >= (1 << CNT_W) ||
      LOW_DB_US_0 * MHZ < 2) begin : g_bad_param
    $error("rvm: unsupported parameter value");
  end

  // Debounce cycle counts, derived from microseconds and clock rate.
  function automatic logic [CNT_W-1:0] us_cyc(input int unsigned us);
    us_cyc = CNT_W'(us * MHZ);
  endfunction

  function automatic logic [CNT_W-1:0] low_db_cyc(input logic [1:0] sel);
    case (sel)
      2'h0: low_db_cyc = us_cyc(LOW_DB_US_0);
      2'h1: low_db_cyc = us_cyc(LOW_DB_US_1);
      2'h2: low_db_cyc = us_cyc(LOW_DB_US_2);
      default: low_db_cyc = us_cyc(LOW_DB_US_3);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] high_db_cyc(input logic [1:0] sel);
    case (sel)
      2'h0: high_db_cyc = us_cyc(HIGH_DB_US_0);
      2'h1: high_db_cyc = us_cyc(HIGH_DB_US_1);
      2'h2: high_db_cyc = us_cyc(HIGH_DB_US_2);
      default: high_db_cyc = us_cyc(HIGH_DB_US_3);
    endcase
  endfunction

  // Trip percentage decoding shared by every regulator.
  function automatic logic [6:0] low_pct(input logic [1:0] sel);
    case (sel)
      2'h0: low_pct = LOW_PCT_0;
      2'h1: low_pct = LOW_PCT_1;
      2'h2: low_pct = LOW_PCT_2;
      default: low_pct = LOW_PCT_3;
    endcase
  endfunction

  function automatic logic [6:0] high_pct(input logic [1:0] sel);
    case (sel)
      2'h0: high_pct = HIGH_PCT_0;
      2'h1: high_pct = HIGH_PCT_1;
      2'h2: high_pct = HIGH_PCT_2;
      default: high_pct = HIGH_PCT_3;
    endcase
  endfunction

  // Comparator and regulator pins are asynchronous, so each passes two flops.
  // Pin synchronisers: the first stage feeds only the second.
  logic [10:0] low_m_reg, low_s_reg, high_m_reg, high_s_reg;
  logic [10:0] on_m_reg, on_s_reg, regd_m_reg, regd_s_reg;
  logic [1:0] ref_m_reg, ref_s_reg;
  always_ff @(posedge core_clk_i) begin
    low_m_reg <= low_cmp_i;
    low_s_reg <= low_m_reg;
    high_m_reg <= high_cmp_i;
    high_s_reg <= high_m_reg;
    on_m_reg <= reg_on_i;
    on_s_reg <= on_m_reg;
    regd_m_reg <= in_regulation_i;
    regd_s_reg <= regd_m_reg;
    ref_m_reg <= {system_on_i, ref_drift_i};
    ref_s_reg <= ref_m_reg;
  end

  // Configuration registers.
  logic [1:0] low_db_reg, high_db_reg;
  logic secure_reg, irq_only_reg, key_ok_reg;
  logic [10:0] mon_en_reg;
  logic [21:0] low_sel_reg, high_sel_reg;
  logic [2:0] irq_stat_reg, irq_mask_reg;
  logic [10:0] low_stat_reg, high_stat_reg;
  logic ref_stat_reg;
  logic wr_cyc, rd_cyc, rd_req;

  // Every access takes one wait cycle. A transfer completes at the edge where
  // waitrequest is low; writes land and read-clear side effects happen there.
  assign wr_cyc = avs_write_i && !avs_waitrequest_o;
  assign rd_cyc = avs_read_i && !avs_waitrequest_o;
  // Read data are loaded on the request edge, so they already stand when the
  // master samples waitrequest low; the cost is one cycle of staleness.
  assign rd_req = avs_read_i && avs_waitrequest_o;

  // Waitrequest idles high and drops for exactly one cycle per request.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Control and mask fields ride on byte lane 0; the select registers need all four lanes.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      low_db_reg <= LOW_DB_RST;
      high_db_reg <= HIGH_DB_RST;
      secure_reg <= 1'b0;
      irq_only_reg <= 1'b0;
      low_sel_reg <= '0;
      high_sel_reg <= '0;
      irq_mask_reg <= '0;
    end else if (wr_cyc) begin
      if (avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
        low_db_reg <= avs_writedata_i[CTRL_LOW_DB_LSB +: 2];
        high_db_reg <= avs_writedata_i[CTRL_HIGH_DB_LSB +: 2];
        secure_reg <= avs_writedata_i[CTRL_SECURE_BIT];
        irq_only_reg <= avs_writedata_i[CTRL_IRQ_ONLY_BIT];
      end
      if (avs_address_i == OFS_LOW_SEL && avs_byteenable_i == 4'hF) begin
        low_sel_reg <= avs_writedata_i[21:0];
      end
      if (avs_address_i == OFS_HIGH_SEL && avs_byteenable_i == 4'hF) begin
        high_sel_reg <= avs_writedata_i[21:0];
      end
      if (avs_address_i == OFS_IRQ_MASK && avs_byteenable_i[0]) begin
        irq_mask_reg <= avs_writedata_i[2:0];
      end
    end
  end

  // Secure write: the key arms only the very next write, which must be the enable write.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      key_ok_reg <= 1'b0;
    end else if (wr_cyc) begin
      key_ok_reg <= avs_address_i == OFS_SECURE_KEY && avs_writedata_i == SECURE_KEY;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mon_en_reg <= MON_EN_RST;
    end else if (wr_cyc && avs_address_i == OFS_MON_EN && avs_byteenable_i[1:0] == 2'h3) begin
      // A plain write in secure mode is dropped silently; no error is signalled.
      // secure write gate
      if (!secure_reg || key_ok_reg) begin
        mon_en_reg <= avs_writedata_i[10:0];
      end
    end
  end

  // Per-regulator monitors.
  logic [10:0] low_hit, high_hit, low_clr, high_clr;
  logic [CNT_W-1:0] low_lim, high_lim;
  assign low_lim = low_db_cyc(low_db_reg);
  assign high_lim = high_db_cyc(high_db_reg);

  for (genvar g = 0; g < NUM_REG; g++) begin : g_mon
    rvm_state_e st_reg;
    logic [CNT_W-1:0] low_cnt_reg, high_cnt_reg;

    // A regulator that turns off drops back to OFF, so re-enabling masks again.
    // enable gates monitor, mask until regulating
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        st_reg <= RVM_OFF;
      end else begin
        case (st_reg)
          RVM_OFF: if (mon_en_reg[g] && on_s_reg[g]) st_reg <= RVM_MASKED;
          RVM_MASKED: begin
            if (!mon_en_reg[g] || !on_s_reg[g]) st_reg <= RVM_OFF;
            else if (regd_s_reg[g]) st_reg <= RVM_WATCH;
          end
          RVM_WATCH: if (!mon_en_reg[g] || !on_s_reg[g]) st_reg <= RVM_OFF;
          default: st_reg <= RVM_OFF;
        endcase
      end
    end

    // The counter saturates at the limit, so a long excursion trips only once.
    // debounce restarts on excursion end
    always_ff @(posedge core_clk_i) begin
      if (rst_i || st_reg != RVM_WATCH || !low_s_reg[g]) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg < low_lim) begin
        low_cnt_reg <= low_cnt_reg + CNT_W'(1);
      end
      if (rst_i || st_reg != RVM_WATCH || !high_s_reg[g]) begin
        high_cnt_reg <= '0;
      end else if (high_cnt_reg < high_lim) begin
        high_cnt_reg <= high_cnt_reg + CNT_W'(1);
      end
    end

    assign low_hit[g] = st_reg == RVM_WATCH && low_s_reg[g] && low_cnt_reg == low_lim - CNT_W'(1);
    assign high_hit[g] = st_reg == RVM_WATCH && high_s_reg[g] && high_cnt_reg == high_lim - CNT_W'(1);
    assign low_clr[g] = !mon_en_reg[g];
    assign high_clr[g] = !mon_en_reg[g];
  end

  // Live trip status; a disabled monitor reads zero at once.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      low_stat_reg <= '0;
      high_stat_reg <= '0;
    end else begin
      low_stat_reg <= (low_stat_reg & low_s_reg | low_hit) & ~low_clr;
      high_stat_reg <= (high_stat_reg & high_s_reg | high_hit) & ~high_clr;
    end
  end

  // Trip level codes handed to the comparator reference DACs.
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_REG; i++) begin
      low_trip_pct_o[i*7 +: 7] <= low_pct(low_sel_reg[i*2 +: 2]);
      high_trip_pct_o[i*7 +: 7] <= high_pct(high_sel_reg[i*2 +: 2]);
    end
  end

  // Reference monitor and power control.
  logic ref_rise;
  assign ref_rise = ref_s_reg[0] && !ref_stat_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ref_stat_reg <= 1'b0;
      switching_powerup_block_o <= 1'b0;
      power_stage_shutdown_o <= 1'b0;
    end else begin
      ref_stat_reg <= ref_s_reg[0];
      switching_powerup_block_o <= ref_s_reg[0] && !ref_s_reg[1];
      // Shutdown latches until the system leaves the on state, so a drift that
      // clears by itself cannot restart the power stages.
      // bypass selects action
      if (ref_s_reg[0] && ref_s_reg[1] && !irq_only_reg) begin
        power_stage_shutdown_o <= 1'b1;
      end else if (!ref_s_reg[1]) begin
        power_stage_shutdown_o <= 1'b0;
      end
    end
  end

  // Sticky interrupts; a read clears, but a new event in that cycle wins.
  logic [2:0] irq_ev;
  assign irq_ev = {ref_rise, |high_hit, |low_hit};
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      if (rd_cyc && avs_address_i == OFS_IRQ_STAT) begin
        irq_stat_reg <= irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data mux, loaded on the request edge; unmapped addresses read zero.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (rd_req) begin
      case (avs_address_i)
        OFS_CTRL: avs_readdata_o <= {26'h0, irq_only_reg, secure_reg, high_db_reg, low_db_reg};
        OFS_MON_EN: avs_readdata_o <= {21'h0, mon_en_reg};
        OFS_LOW_SEL: avs_readdata_o <= {10'h0, low_sel_reg};
        OFS_HIGH_SEL: avs_readdata_o <= {10'h0, high_sel_reg};
        OFS_LOW_STAT: avs_readdata_o <= {21'h0, low_stat_reg};
        OFS_HIGH_STAT: avs_readdata_o <= {21'h0, high_stat_reg};
        // Include this cycle's events: the clear at the accept edge would lose them.
        OFS_IRQ_STAT: avs_readdata_o <= {29'h0, irq_stat_reg | irq_ev};
        OFS_IRQ_MASK: avs_readdata_o <= {29'h0, irq_mask_reg};
        OFS_REF_STAT: avs_readdata_o <= {31'h0, ref_stat_reg};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // Assertions.
  chk_low_db_reset: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> low_db_reg == LOW_DB_RST) else $error("low debounce reset wrong");
  chk_high_db_reset: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> high_db_reg == HIGH_DB_RST) else $error("high debounce reset wrong");
  chk_enable_reset: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> mon_en_reg == MON_EN_RST) else $error("enables not set after reset");
  chk_secure_ignore: assert property (@(posedge core_clk_i) disable iff (rst_i)
    secure_reg && !key_ok_reg && !$past(rst_i) |=> $stable(mon_en_reg))
    else $error("enable changed without secure write");
  chk_disable_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !mon_en_reg[0] |=> !low_stat_reg[0] && !high_stat_reg[0])
    else $error("status not cleared on disable");
  chk_mask_regulate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(g_mon[0].st_reg == RVM_WATCH) |-> $past(regd_s_reg[0]))
    else $error("fault watch armed before regulation");
  chk_shutdown_bypass: assert property (@(posedge core_clk_i) disable iff (rst_i)
    irq_only_reg && !power_stage_shutdown_o |=> !power_stage_shutdown_o)
    else $error("shutdown in interrupt-only mode");
  chk_ref_status: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 ref_stat_reg == $past(ref_s_reg[0])) else $error("reference status not live");
  chk_ref_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ref_rise |=> irq_stat_reg[IRQ_REF_BIT]) else $error("reference flag not set");
  chk_low_debounce: assert property (@(posedge core_clk_i) disable iff (rst_i)
    low_hit[0] |-> $past(low_s_reg[0], 2)) else $error("low trip without persistence");

  // Main scenarios that the bench is expected to reach.
  cov_low_trip: cover property (@(posedge core_clk_i) disable iff (rst_i) low_hit[0]);
  cov_secure_write: cover property (@(posedge core_clk_i) disable iff (rst_i)
    secure_reg && key_ok_reg && wr_cyc && avs_address_i == OFS_MON_EN);
  cov_high_trip: cover property (@(posedge core_clk_i) disable iff (rst_i) high_hit[0]);
  cov_shutdown: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(power_stage_shutdown_o));
  cov_irq: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(irq_o));

endmodule // rvm_regulator_voltage_monitor
`default_nettype wire

/* sim/rvm_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module rvm_far_side #(
  parameter int SETTLE = 40
) (
  // Clock.
  input wire logic clk_i,
  // Commands from the bench.
  input wire logic [10:0] turn_on_i,
  input wire logic [10:0] lo_force_i,
  input wire logic [10:0] hi_force_i,
  input wire logic drift_i,
  input wire logic sys_on_i,
  // Analog side as the monitor sees it.
  output logic [10:0] low_cmp_o,
  output logic [10:0] high_cmp_o,
  output logic [10:0] reg_on_o,
  output logic [10:0] in_regulation_o,
  output logic ref_drift_o,
  output logic system_on_o
);
  int ramp [11];

  // A rail ramps for SETTLE cycles before it reports regulation, so masking is observable.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 11; i++) begin
      ramp[i] <= turn_on_i[i] ? ((ramp[i] < SETTLE) ? ramp[i] + 1 : SETTLE) : 0;
    end
  end

  // Regulation is reported only while the rail stays on.
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      in_regulation_o[i] = turn_on_i[i] && (ramp[i] >= SETTLE);
    end
  end

  // Comparators and reference follow the commanded analog conditions.
  assign reg_on_o = turn_on_i;
  assign low_cmp_o = lo_force_i;
  assign high_cmp_o = hi_force_i;
  assign ref_drift_o = drift_i;
  assign system_on_o = sys_on_i;
endmodule // rvm_far_side
`default_nettype wire

/* sim/rvm_regulator_voltage_monitor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rvm_regulator_voltage_monitor_tb_top import rvm_pkg::*;;
  localparam int unsigned MHZ_TB = 2;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [10:0] low_cmp_i, high_cmp_i, reg_on_i, in_regulation_i;
  logic ref_drift_i, system_on_i;
  logic [76:0] low_trip_pct_o, high_trip_pct_o;
  logic switching_powerup_block_o, power_stage_shutdown_o, irq_o;
  logic [10:0] turn_on = 11'h7FF;
  logic [10:0] lo_f = 11'h000;
  logic [10:0] hi_f = 11'h000;
  logic drift = 1'b0;
  logic sys_on = 1'b0;
  logic [31:0] q;
  int n_mismatch = 0;
  int check_count = 0;
  int lo_us [4] = '{LOW_DB_US_0, LOW_DB_US_1, LOW_DB_US_2, LOW_DB_US_3};
  int hi_us [4] = '{HIGH_DB_US_0, HIGH_DB_US_1, HIGH_DB_US_2, HIGH_DB_US_3};
  logic [6:0] lo_pct [4] = '{LOW_PCT_0, LOW_PCT_1, LOW_PCT_2, LOW_PCT_3};
  logic [6:0] hi_pct [4] = '{HIGH_PCT_0, HIGH_PCT_1, HIGH_PCT_2, HIGH_PCT_3};

  // Free-running 50 MHz clock.
  always #10 core_clk_i = ~core_clk_i;

  // A smaller clock rate shortens every debounce count.
  rvm_regulator_voltage_monitor #(.MHZ(MHZ_TB)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .low_cmp_i(low_cmp_i), .high_cmp_i(high_cmp_i),
    .reg_on_i(reg_on_i), .in_regulation_i(in_regulation_i), .ref_drift_i(ref_drift_i),
    .system_on_i(system_on_i), .low_trip_pct_o(low_trip_pct_o),
    .high_trip_pct_o(high_trip_pct_o), .switching_powerup_block_o(switching_powerup_block_o),
    .power_stage_shutdown_o(power_stage_shutdown_o), .irq_o(irq_o));

  rvm_far_side #(.SETTLE(40)) i_far (
    .clk_i(core_clk_i), .turn_on_i(turn_on), .lo_force_i(lo_f), .hi_force_i(hi_f),
    .drift_i(drift), .sys_on_i(sys_on), .low_cmp_o(low_cmp_i), .high_cmp_o(high_cmp_i),
    .reg_on_o(reg_on_i), .in_regulation_o(in_regulation_i), .ref_drift_o(ref_drift_i),
    .system_on_o(system_on_i));

  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [76:0] got, input logic [76:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // One Avalon-MM transfer; read data is taken at the edge where waitrequest is low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (n >= 64) begin
      n_mismatch++;
      wrap_up();
    end else begin
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask

  task automatic reset_scn();
    bus(1'b0, OFS_CTRL, 32'h0);
    check(q[3:0], 4'h2);
    bus(1'b0, OFS_MON_EN, 32'h0);
    check(q[10:0], MON_EN_RST);
    check(low_trip_pct_o, {11{LOW_PCT_0}});
    check(high_trip_pct_o, {11{HIGH_PCT_0}});
    bus(1'b0, 6'h3C, 32'h0);
    check(q, 32'h0);
  endtask

  // Neighbouring regulators get different codes so a shared or swapped field shows up.
  task automatic trip_scn();
    logic [31:0] sel = 32'h0;
    logic [76:0] el = '0;
    logic [76:0] eh = '0;
    for (int i = 0; i < 11; i++) begin
      sel[2*i+:2] = 2'((i + 1) % 4);
      el[7*i+:7] = lo_pct[(i + 1) % 4];
      eh[7*i+:7] = hi_pct[(i + 1) % 4];
    end
    bus(1'b1, OFS_LOW_SEL, sel);
    bus(1'b1, OFS_HIGH_SEL, sel);
    tick(3);
    check(low_trip_pct_o, el);
    check(high_trip_pct_o, eh);
  endtask

  // A short excursion must restart the count; a steady one trips near the selected time.
  task automatic debounce_scn(input bit hi, input int code);
    int d;
    d = (hi ? hi_us[code] : lo_us[code]) * MHZ_TB;
    bus(1'b1, OFS_CTRL, hi ? 32'(code << CTRL_HIGH_DB_LSB) : 32'(code));
    for (int k = 0; k < 2; k++) begin
      if (hi) hi_f[0] <= 1'b1; else lo_f[0] <= 1'b1;
      tick(d - 4);
      if (k == 0) begin
        if (hi) hi_f[0] <= 1'b0; else lo_f[0] <= 1'b0;
        tick(3);
      end
    end
    bus(1'b0, hi ? OFS_HIGH_STAT : OFS_LOW_STAT, 32'h0);
    check(q[0], 1'b0);
    tick(14);
    bus(1'b0, hi ? OFS_HIGH_STAT : OFS_LOW_STAT, 32'h0);
    check(q[0], 1'b1);
    if (hi) hi_f[0] <= 1'b0; else lo_f[0] <= 1'b0;
    tick(4);
  endtask

  task automatic enable_scn();
    bus(1'b1, OFS_CTRL, 32'h0);
    lo_f[0] <= 1'b1;
    tick(24);
    bus(1'b1, OFS_MON_EN, 32'h7FE);
    bus(1'b0, OFS_LOW_STAT, 32'h0);
    check(q[0], 1'b0);
    tick(30);
    bus(1'b0, OFS_LOW_STAT, 32'h0);
    check(q[0], 1'b0);
    bus(1'b1, OFS_CTRL, 32'(1 << CTRL_SECURE_BIT));
    bus(1'b1, OFS_MON_EN, 32'h7FF);
    bus(1'b0, OFS_MON_EN, 32'h0);
    check(q[10:0], 11'h7FE);
    bus(1'b1, OFS_SECURE_KEY, SECURE_KEY);
    bus(1'b1, OFS_MON_EN, 32'h7FF);
    bus(1'b0, OFS_MON_EN, 32'h0);
    check(q[10:0], 11'h7FF);
    tick(30);
    bus(1'b0, OFS_LOW_STAT, 32'h0);
    check(q[0], 1'b1);
    lo_f[0] <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0);
  endtask

  // The rail ramps for 40 cycles, longer than the 10-cycle debounce, while already tripping.
  task automatic mask_scn();
    turn_on[1] <= 1'b0;
    tick(5);
    turn_on[1] <= 1'b1;
    lo_f[1] <= 1'b1;
    tick(28);
    bus(1'b0, OFS_LOW_STAT, 32'h0);
    check(q[1], 1'b0);
    tick(40);
    bus(1'b0, OFS_LOW_STAT, 32'h0);
    check(q[1], 1'b1);
    lo_f[1] <= 1'b0;
  endtask

  task automatic ref_scn();
    bus(1'b1, OFS_IRQ_MASK, 32'(1 << IRQ_REF_BIT));
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    drift <= 1'b1;
    tick(8);
    check(switching_powerup_block_o, 1'b1);
    check(irq_o, 1'b1);
    bus(1'b0, OFS_REF_STAT, 32'h0);
    check(q[0], 1'b1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    check(q[IRQ_REF_BIT], 1'b1);
    tick(3);
    check(irq_o, 1'b0);
    drift <= 1'b0;
    sys_on <= 1'b1;
    tick(8);
    bus(1'b0, OFS_REF_STAT, 32'h0);
    check(q[0], 1'b0);
    drift <= 1'b1;
    tick(8);
    check(power_stage_shutdown_o, 1'b1);
    drift <= 1'b0;
    sys_on <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'(1 << CTRL_IRQ_ONLY_BIT));
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    sys_on <= 1'b1;
    tick(8);
    drift <= 1'b1;
    tick(8);
    check(power_stage_shutdown_o, 1'b0);
    check(irq_o, 1'b0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    check(q[IRQ_REF_BIT], 1'b1);
  endtask

  // Main sequence: hold reset for 8 cycles, let the rails settle, then run each scenario.
  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(44);
    reset_scn();
    trip_scn();
    for (int c = 0; c < 4; c++) debounce_scn(1'b1, c);
    for (int c = 0; c < 4; c++) debounce_scn(1'b0, c);
    enable_scn();
    mask_scn();
    ref_scn();
    wrap_up();
  end
endmodule // rvm_regulator_voltage_monitor_tb_top
`default_nettype wire
